// *** core/ubg_counter.sv ***
`timescale 1ns/1ps
module ubg_counter #(
  parameter logic [ubg_pkg::UBG_OSC_W-1:0] OSC_PER_CYC = ubg_pkg::UBG_OSC_PER_CYC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Configuration
  input wire ubg_pkg::ubg_cfg_t cfg_in,
  // Results
  output ubg_pkg::ubg_tick_t tick_out,
  output ubg_pkg::ubg_stat_t stat_out
);
  import ubg_pkg::*;

  typedef struct packed {
    logic [UBG_OSC_W-1:0] osc_cnt;
    logic [UBG_CNT_W-1:0] count;
    logic [UBG_PH_W-1:0] phase;
    logic sample_tick;
    logic baud_tick;
  } ubg_cnt_state_t;

  ubg_cnt_state_t s;
  ubg_cnt_state_t next_s;
  logic cyc_en;
  logic [UBG_PH_W-1:0] ph_last;

  // Instruction clock is a one-cycle enable from the oscillator divider
  assign cyc_en = (s.osc_cnt == OSC_PER_CYC - 2'h1); // [R8]
  assign ph_last = cfg_in.high_speed ? UBG_PH_LAST_HIGH : UBG_PH_LAST_NORMAL; // [R3] [R4]

  always_comb
  begin
    next_s = s;
    next_s.sample_tick = 1'b0;
    next_s.baud_tick = 1'b0;
    if (!cfg_in.enable || cfg_in.clear)
    begin
      // A divisor write restarts the period at once
      next_s.osc_cnt = '0; // [R7]
      next_s.count = '0; // [R7]
      next_s.phase = '0;
    end
    else
    begin
      next_s.osc_cnt = cyc_en ? '0 : s.osc_cnt + 2'h1;
      if (cyc_en)
      begin
        if (s.count == cfg_in.divisor) // [R2] [R5] [R6]
        begin
          next_s.count = '0; // [R9]
          next_s.sample_tick = 1'b1; // [R9]
          // >= keeps a switch to high speed from running the phase past 3
          if (s.phase >= ph_last)
          begin
            next_s.phase = '0;
            next_s.baud_tick = 1'b1; // [R3] [R4]
          end
          else
          begin
            next_s.phase = s.phase + 4'h1;
          end
        end
        else
        begin
          next_s.count = s.count + 16'h0001; // [R1]
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign tick_out.sample_tick = s.sample_tick;
  assign tick_out.baud_tick = s.baud_tick;
  assign stat_out.running = cfg_in.enable;
  assign stat_out.phase = s.phase;
  assign stat_out.count = s.count;

endmodule

// *** core/ubg_pkg.sv ***
package ubg_pkg;

  // Bus geometry
  localparam int unsigned UBG_ADDR_W = 8;
  localparam int unsigned UBG_DATA_W = 32;
  localparam int unsigned UBG_STRB_W = UBG_DATA_W / 8;

  // Generator geometry
  localparam int unsigned UBG_CNT_W = 16;
  localparam int unsigned UBG_PH_W = 4;
  localparam int unsigned UBG_OSC_W = 2;

  // Register byte addresses
  localparam logic [UBG_ADDR_W-1:0] UBG_ADDR_DIVISOR = 8'h00;
  localparam logic [UBG_ADDR_W-1:0] UBG_ADDR_CONTROL = 8'h04;
  localparam logic [UBG_ADDR_W-1:0] UBG_ADDR_STATUS = 8'h08;

  // Control field positions
  localparam int unsigned UBG_CTL_HS_BIT = 0;
  localparam int unsigned UBG_CTL_EN_BIT = 1;

  // Status field positions
  localparam int unsigned UBG_STAT_CNT_LSB = 0;
  localparam int unsigned UBG_STAT_PH_LSB = 16;
  localparam int unsigned UBG_STAT_RUN_BIT = 20;

  // Reset values
  localparam logic [UBG_CNT_W-1:0] UBG_DIVISOR_RST = 16'h0000;
  localparam logic UBG_HS_RST = 1'b0;
  localparam logic UBG_EN_RST = 1'b0;

  // Oscillator cycles per instruction cycle (clock reduction and PLL off)
  localparam logic [UBG_OSC_W-1:0] UBG_OSC_PER_CYC = 2'h2;

  // Last prescaler phase: 16 steps normal speed, 4 steps high speed
  localparam logic [UBG_PH_W-1:0] UBG_PH_LAST_NORMAL = 4'hF;
  localparam logic [UBG_PH_W-1:0] UBG_PH_LAST_HIGH = 4'h3;

  // AXI responses
  localparam logic [1:0] UBG_RESP_OKAY = 2'h0;
  localparam logic [1:0] UBG_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic enable;
    logic high_speed;
    logic [UBG_CNT_W-1:0] divisor;
    logic clear;
  } ubg_cfg_t;

  typedef struct packed {
    logic running;
    logic [UBG_PH_W-1:0] phase;
    logic [UBG_CNT_W-1:0] count;
  } ubg_stat_t;

  typedef struct packed {
    logic sample_tick;
    logic baud_tick;
  } ubg_tick_t;

endpackage

// *** core/ubg_top.sv ***
// Functional notes
// R1 - Free-running 16-bit counter while port enabled
// R2 - Counter period is divisor plus one cycles
// R3 - Normal speed: rate is Fcy/(16*(div+1))
// R4 - High speed: rate is Fcy/(4*(div+1))
// R5 - Normal speed spans Fcy/16 down to 65536 steps
// R6 - High speed spans Fcy/4 down to 65536 steps
// R7 - Divisor write clears the counter at once
// R8 - Runs on instruction clock, half oscillator rate
// R9 - Terminal count reloads and emits one tick
//
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module ubg_top #(
  parameter logic [ubg_pkg::UBG_OSC_W-1:0] OSC_PER_CYC = ubg_pkg::UBG_OSC_PER_CYC
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [ubg_pkg::UBG_ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic [2:0] s_axi_awprot_in,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  input wire logic [ubg_pkg::UBG_DATA_W-1:0] s_axi_wdata_in,
  input wire logic [ubg_pkg::UBG_STRB_W-1:0] s_axi_wstrb_in,
  // AXI4-Lite write response
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  output logic [1:0] s_axi_bresp_out,
  // AXI4-Lite read address
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  input wire logic [ubg_pkg::UBG_ADDR_W-1:0] s_axi_araddr_in,
  input wire logic [2:0] s_axi_arprot_in,
  // AXI4-Lite read data
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [ubg_pkg::UBG_DATA_W-1:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  // Timing to transmitter and receiver
  output ubg_pkg::ubg_tick_t tick_out,
  output logic high_speed_baud_select_out
);
  import ubg_pkg::*;

  typedef struct packed {
    logic aw_held;
    logic [UBG_ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [UBG_DATA_W-1:0] w_data;
    logic [UBG_STRB_W-1:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [UBG_DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic [UBG_CNT_W-1:0] baud_divisor;
    logic high_speed;
    logic enable;
    logic div_wr;
  } ubg_regs_t;

  logic [1:0] rst_sync;
  logic rst_n;
  ubg_regs_t s;
  ubg_regs_t next_s;
  ubg_cfg_t cfg;
  ubg_stat_t stat;
  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic have_aw;
  logic have_w;
  logic [UBG_ADDR_W-1:0] wr_addr;
  logic [UBG_DATA_W-1:0] wr_data;
  logic [UBG_STRB_W-1:0] wr_strb;

  // Reset is asserted at once and released after two clean edges
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rst_sync <= 2'h0;
    end
    else
    begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // Merge byte lanes of a write into the old register image
  function automatic logic [UBG_DATA_W-1:0] merge_bytes(
    input logic [UBG_DATA_W-1:0] old_val,
    input logic [UBG_DATA_W-1:0] new_val,
    input logic [UBG_STRB_W-1:0] strb
  );
    logic [UBG_DATA_W-1:0] res;
    res = old_val;
    for (int i = 0; i < UBG_STRB_W; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Register image as software reads it
  function automatic logic [UBG_DATA_W-1:0] read_image(
    input logic [UBG_ADDR_W-1:0] addr,
    input ubg_regs_t r,
    input ubg_stat_t st
  );
    logic [UBG_DATA_W-1:0] img;
    img = '0;
    unique case (addr)
      UBG_ADDR_DIVISOR:
      begin
        img[UBG_CNT_W-1:0] = r.baud_divisor;
      end
      UBG_ADDR_CONTROL:
      begin
        img[UBG_CTL_HS_BIT] = r.high_speed;
        img[UBG_CTL_EN_BIT] = r.enable;
      end
      UBG_ADDR_STATUS:
      begin
        img[UBG_STAT_CNT_LSB +: UBG_CNT_W] = st.count;
        img[UBG_STAT_PH_LSB +: UBG_PH_W] = st.phase;
        img[UBG_STAT_RUN_BIT] = st.running;
      end
      default:
      begin
        img = '0;
      end
    endcase
    return img;
  endfunction

  function automatic logic addr_mapped(input logic [UBG_ADDR_W-1:0] addr);
    return (addr == UBG_ADDR_DIVISOR) || (addr == UBG_ADDR_CONTROL) ||
      (addr == UBG_ADDR_STATUS);
  endfunction

  // A held response blocks new writes, so one write at most is in flight
  assign s_axi_awready_out = !s.aw_held && !s.bvalid;
  assign s_axi_wready_out = !s.w_held && !s.bvalid;
  assign s_axi_arready_out = !s.rvalid;
  assign aw_fire = s_axi_awvalid_in && s_axi_awready_out;
  assign w_fire = s_axi_wvalid_in && s_axi_wready_out;
  assign ar_fire = s_axi_arvalid_in && s_axi_arready_out;
  assign have_aw = s.aw_held || aw_fire;
  assign have_w = s.w_held || w_fire;
  assign wr_addr = s.aw_held ? s.aw_addr : s_axi_awaddr_in;
  assign wr_data = s.w_held ? s.w_data : s_axi_wdata_in;
  assign wr_strb = s.w_held ? s.w_strb : s_axi_wstrb_in;

  always_comb
  begin
    logic [UBG_DATA_W-1:0] merged;
    merged = '0;
    next_s = s;
    next_s.div_wr = 1'b0;

    // Address and data may arrive in either order
    if (aw_fire)
    begin
      next_s.aw_held = 1'b1;
      next_s.aw_addr = s_axi_awaddr_in;
    end
    if (w_fire)
    begin
      next_s.w_held = 1'b1;
      next_s.w_data = s_axi_wdata_in;
      next_s.w_strb = s_axi_wstrb_in;
    end

    if (have_aw && have_w && !s.bvalid)
    begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = addr_mapped(wr_addr) ? UBG_RESP_OKAY : UBG_RESP_SLVERR;
      merged = merge_bytes(read_image(wr_addr, s, stat), wr_data, wr_strb);
      if (wr_addr == UBG_ADDR_DIVISOR)
      begin
        next_s.baud_divisor = merged[UBG_CNT_W-1:0]; // [R2]
        // Any divisor write restarts the count, even with no lane enabled
        next_s.div_wr = 1'b1; // [R7]
      end
      if (wr_addr == UBG_ADDR_CONTROL)
      begin
        next_s.high_speed = merged[UBG_CTL_HS_BIT]; // [R3] [R4]
        next_s.enable = merged[UBG_CTL_EN_BIT]; // [R1]
      end
    end
    else if (s.bvalid && s_axi_bready_in)
    begin
      next_s.bvalid = 1'b0;
    end

    if (ar_fire)
    begin
      next_s.rvalid = 1'b1;
      next_s.rdata = read_image(s_axi_araddr_in, s, stat);
      next_s.rresp = addr_mapped(s_axi_araddr_in) ? UBG_RESP_OKAY : UBG_RESP_SLVERR;
    end
    else if (s.rvalid && s_axi_rready_in)
    begin
      next_s.rvalid = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '{
        aw_held: 1'b0,
        aw_addr: '0,
        w_held: 1'b0,
        w_data: '0,
        w_strb: '0,
        bvalid: 1'b0,
        bresp: UBG_RESP_OKAY,
        rvalid: 1'b0,
        rdata: '0,
        rresp: UBG_RESP_OKAY,
        baud_divisor: UBG_DIVISOR_RST,
        high_speed: UBG_HS_RST,
        enable: UBG_EN_RST,
        div_wr: 1'b0
      };
    end
    else
    begin
      s <= next_s;
    end
  end

  assign cfg.enable = s.enable;
  assign cfg.high_speed = s.high_speed;
  assign cfg.divisor = s.baud_divisor;
  assign cfg.clear = s.div_wr; // [R7]

  ubg_counter #(
    .OSC_PER_CYC(OSC_PER_CYC)
  ) u_counter (
    .clk_in(ref_clk_in),
    .rst_n_in(rst_n),
    .cfg_in(cfg),
    .tick_out(tick_out),
    .stat_out(stat)
  );

  assign s_axi_bvalid_out = s.bvalid;
  assign s_axi_bresp_out = s.bresp;
  assign s_axi_rvalid_out = s.rvalid;
  assign s_axi_rdata_out = s.rdata;
  assign s_axi_rresp_out = s.rresp;
  assign high_speed_baud_select_out = s.high_speed;

endmodule

// *** verif/ubg_monitor.sv ***
`timescale 1ns/1ps
module ubg_monitor
  import ubg_pkg::*;
#(
  parameter logic [ubg_pkg::UBG_OSC_W-1:0] OSC_PER_CYC = ubg_pkg::UBG_OSC_PER_CYC
) (
  // Watched ports
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic [ubg_pkg::UBG_ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic [ubg_pkg::UBG_DATA_W-1:0] s_axi_wdata_in,
  input wire logic [ubg_pkg::UBG_STRB_W-1:0] s_axi_wstrb_in,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic [ubg_pkg::UBG_DATA_W-1:0] s_axi_rdata_out,
  input wire ubg_pkg::ubg_tick_t tick_out,
  input wire logic high_speed_baud_select_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!nrst_in);
  sequence s_wr_both;
    s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
  endsequence
  // The select bit is a flop loaded at the write edge, so it shows one cycle later
  property p_hs;
    s_wr_both ##0 (s_axi_awaddr_in == UBG_ADDR_CONTROL && s_axi_wstrb_in[0])
      |=> high_speed_baud_select_out == $past(s_axi_wdata_in[UBG_CTL_HS_BIT]);
  endproperty
  chk_b_hold: assert property (
    s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response dropped early");
  chk_r_hold: assert property (
    s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read data dropped early");
  chk_wr_block: assert property (
    s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
    else $error("write accepted with response pending");
  chk_ar_block: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("read accepted with data pending");
  chk_wr_answer: assert property (s_wr_both |=> s_axi_bvalid_out)
    else $error("no write response");
  chk_rd_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("no read data");
  chk_tick_single: assert property (tick_out.sample_tick |=> !tick_out.sample_tick)
    else $error("sample tick wider than one cycle");
  chk_baud_single: assert property (tick_out.baud_tick |=> !tick_out.baud_tick)
    else $error("baud tick wider than one cycle");
  chk_baud_align: assert property (tick_out.baud_tick |-> tick_out.sample_tick)
    else $error("baud tick off the sample grid");
  chk_hs_follow: assert property (p_hs)
    else $error("speed select not following control");
endmodule
bind ubg_top ubg_monitor #(.OSC_PER_CYC(OSC_PER_CYC)) u_mon (.ref_clk_in, .nrst_in,
  .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_awaddr_in, .s_axi_wvalid_in,
  .s_axi_wready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_bvalid_out, .s_axi_bready_in,
  .s_axi_bresp_out, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rvalid_out,
  .s_axi_rready_in, .s_axi_rdata_out, .tick_out, .high_speed_baud_select_out);

// *** verif/ubg_top_bench.sv ***
`timescale 1ns/1ps
module ubg_top_bench;
  import ubg_pkg::*;
  logic clk, nrst, awv, awr, wv, wr_, bv, brd, arv, arr, rv, rrd, hs;
  logic [7:0] awa, ara;
  logic [31:0] wd, rd;
  logic [3:0] ws;
  logic [1:0] bre, rre, r;
  logic [15:0] sp, bp, bn, n;
  logic [31:0] q;
  ubg_tick_t tk;
  int error_cnt = 0;
  int num_checks = 0;
  ubg_top dut (.ref_clk_in(clk), .nrst_in(nrst), .s_axi_awvalid_in(awv),
    .s_axi_awready_out(awr), .s_axi_awaddr_in(awa), .s_axi_awprot_in(3'h0),
    .s_axi_wvalid_in(wv), .s_axi_wready_out(wr_), .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws),
    .s_axi_bvalid_out(bv), .s_axi_bready_in(brd), .s_axi_bresp_out(bre),
    .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_araddr_in(ara),
    .s_axi_arprot_in(3'h0), .s_axi_rvalid_out(rv), .s_axi_rready_in(rrd),
    .s_axi_rdata_out(rd), .s_axi_rresp_out(rre), .tick_out(tk),
    .high_speed_baud_select_out(hs));
  ubg_uart_timing far (.clk_in(clk), .rst_n_in(nrst), .tick_in(tk), .samp_per_out(sp),
    .baud_per_out(bp), .baud_cnt_out(bn));
  initial
  begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic at, wt, ad, wn;
    ad = 0;
    wn = 0;
    @(posedge clk);
    awv <= 1; awa <= a; wv <= 1; wd <= d; brd <= 1;
    while (!(ad && wn))
    begin
      @(negedge clk);
      at = awv && (awr === 1'b1);
      wt = wv && (wr_ === 1'b1);
      @(posedge clk);
      if (at) awv <= 0;
      if (wt) wv <= 0;
      ad = ad | at;
      wn = wn | wt;
    end
    do
    begin
      @(negedge clk);
      at = (bv === 1'b1);
      r = bre;
      @(posedge clk);
    end
    while (!at);
    brd <= 0;
  endtask
  task automatic rdt(input logic [7:0] a);
    logic t;
    @(posedge clk);
    arv <= 1; ara <= a; rrd <= 1;
    do
    begin
      @(negedge clk);
      t = arv && (arr === 1'b1);
      @(posedge clk);
    end
    while (!t);
    arv <= 0;
    do
    begin
      @(negedge clk);
      t = (rv === 1'b1);
      q = rd;
      r = rre;
      @(posedge clk);
    end
    while (!t);
    rrd <= 0;
  endtask
  task automatic t_reset;
    repeat (40) @(posedge clk);
    chk(bn, 16'h0000);
    rdt(UBG_ADDR_DIVISOR);
    chk(q, {16'h0000, UBG_DIVISOR_RST});
    chk(r, UBG_RESP_OKAY);
    rdt(UBG_ADDR_STATUS);
    chk(q, 32'h0000_0000);
    rdt(8'h0C);
    chk(r, UBG_RESP_SLVERR);
    chk(q, 32'h0000_0000);
    $display("reset test done");
  endtask
  task automatic t_rate(input logic [15:0] d, input logic h);
    logic [15:0] e;
    wr(UBG_ADDR_CONTROL, {30'h0, 1'b1, h});
    wr(UBG_ADDR_DIVISOR, {16'h0000, d});
    chk(r, UBG_RESP_OKAY);
    e = bn;
    wait (bn == e + 16'h0003);
    // The partner's periods update on the same edge as its count
    @(negedge clk);
    e = UBG_OSC_PER_CYC * (d + 16'h0001);
    chk(sp, e);
    chk(bp, h ? e * 16'h0004 : e * 16'h0010);
    chk(hs, h);
    $display("rate test done");
  endtask
  task automatic t_clear;
    wr(UBG_ADDR_CONTROL, 32'h0000_0002);
    wr(UBG_ADDR_DIVISOR, 32'h0000_00C8);
    repeat (100) @(posedge clk);
    wr(UBG_ADDR_DIVISOR, 32'h1234_0001);
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (tk.sample_tick !== 1'b1);
    chk(n <= 16'h0008, 1'b1);
    rdt(UBG_ADDR_DIVISOR);
    chk(q, 32'h0000_0001);
    rdt(UBG_ADDR_CONTROL);
    chk(q, 32'h0000_0002);
    rdt(UBG_ADDR_STATUS);
    chk(q[UBG_STAT_RUN_BIT], 1'b1);
    chk(q[UBG_STAT_CNT_LSB +: UBG_CNT_W] <= 16'h0001, 1'b1);
    wr(8'h10, 32'h0000_FFFF);
    chk(r, UBG_RESP_SLVERR);
    wr(UBG_ADDR_CONTROL, 32'h0000_0000);
    @(negedge clk);
    n = bn;
    repeat (100) @(posedge clk);
    chk(bn, n);
    rdt(UBG_ADDR_STATUS);
    chk(q, 32'h0000_0000);
    $display("clear test done");
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    // Long enough for every rate case at three bit periods each
    repeat (20000) @(posedge clk);
    error_cnt++;
    wrap_up();
  end
  initial
  begin
    nrst = 0; awv = 0; awa = 0; wv = 0; wd = 0; ws = 4'hF; brd = 0; arv = 0; ara = 0;
    rrd = 0;
    repeat (4) @(posedge clk);
    nrst <= 1;
    repeat (3) @(posedge clk);
    t_reset();
    t_rate(16'h0000, 1'b0);
    t_rate(16'h0000, 1'b1);
    t_rate(16'h0005, 1'b0);
    t_rate(16'h0003, 1'b1);
    t_clear();
    wrap_up();
  end
endmodule

// *** verif/ubg_uart_timing.sv ***
`timescale 1ns/1ps
module ubg_uart_timing
  import ubg_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Ticks from the generator
  input wire ubg_pkg::ubg_tick_t tick_in,
  // Measured spacing
  output logic [15:0] samp_per_out,
  output logic [15:0] baud_per_out,
  output logic [15:0] baud_cnt_out
);
  logic [15:0] sc;
  logic [15:0] bc;
  // First periods after a change are partial; readers skip a few ticks
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sc <= 16'h0001;
      bc <= 16'h0001;
      samp_per_out <= 16'h0000;
      baud_per_out <= 16'h0000;
      baud_cnt_out <= 16'h0000;
    end
    else
    begin
      sc <= tick_in.sample_tick ? 16'h0001 : sc + 16'h0001;
      bc <= tick_in.baud_tick ? 16'h0001 : bc + 16'h0001;
      if (tick_in.sample_tick)
        samp_per_out <= sc;
      if (tick_in.baud_tick)
      begin
        baud_per_out <= bc;
        baud_cnt_out <= baud_cnt_out + 16'h0001;
      end
    end
  end
endmodule
